// file: inc/sbba_map.vh
`ifndef SBBA_MAP_VH
`define SBBA_MAP_VH
// register offsets
`define SBBA_OFS_DATA 8'hb0
`define SBBA_OFS_WORD 8'hb1
`define SBBA_OFS_TARGET 8'hb2
`define SBBA_OFS_CTRL 8'hb3
// reset values
`define SBBA_RST_BYTE 8'h00
// fields of the control and status register
`define SBBA_CTRL_MODE 7
`define SBBA_CTRL_BUSY 5
`define SBBA_CTRL_ENABLE 3
`define SBBA_CTRL_FAULT 1
// fields of the target register
`define SBBA_TGT_RW 0
// timing: one quarter of a serial bit at about 60 kHz
`define SBBA_CLK_MHZ 25
`define SBBA_QUARTER_NS 4166
`define SBBA_QUARTER_CYC ((`SBBA_QUARTER_NS * `SBBA_CLK_MHZ + 999) / 1000)
// sequencer states
`define SBBA_ST_IDLE 3'h0
`define SBBA_ST_START 3'h1
`define SBBA_ST_SEND 3'h2
`define SBBA_ST_RECV 3'h3
`define SBBA_ST_RSTART 3'h4
`define SBBA_ST_STOP 3'h5
`endif

// file: rtl/sbba_serial_bus_byte_access.v
`timescale 1ns/1ps
`default_nettype none
`include "sbba_map.vh"

// Functional notes
// - A software write of the target register starts one bus cycle if idle and enabled.
// - A read cycle stores the received byte in the data register.
// - Data, word and target registers clear to 00h on every reset.
// - The word register gives the byte address inside the target.
// - Target bits 7:1 hold the seven-bit address sent on the bus.
// - Target bit 0 selects write when 0 and read when 1.
// - The busy flag reads 1 while a launched cycle runs, else 0.
// - Mode bit 0 sends target and word address, 1 only the target.
// - A missing acknowledge sets a fault flag cleared by reading it.
// - The bus pins act only while the present-enable bit is 1.
module sbba_serial_bus_byte_access (
    input wire i_clock,
    input wire i_rst,
    input wire i_global_reset_pin_n,
    input wire i_link_reset_n,
    input wire [7:0] i_reg_addr,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [7:0] i_reg_wdata,
    output reg [7:0] o_reg_rdata,
    input wire i_scl_in,
    output wire o_scl_out,
    output wire o_scl_oe,
    input wire i_sda_in,
    output wire o_sda_out,
    output wire o_sda_oe,
    output wire o_serial_mode
);
    localparam [31:0] QCYC_FULL = `SBBA_QUARTER_CYC;
    localparam [7:0] QCYC = QCYC_FULL[7:0];

    reg [1:0] global_reset_pin_sync;
    reg [1:0] lrst_sync;
    reg [1:0] sda_sync;
    reg [1:0] scl_sync;
    reg [7:0] serial_byte_buffer;
    reg [7:0] serial_word_location;
    reg [7:0] serial_target_and_command;
    reg addr_mode_select;
    reg eeprom_present_enable;
    reg cycle_fault_flag;
    reg [2:0] state;
    reg [2:0] step;
    reg [1:0] quarter;
    reg [3:0] bitcnt;
    reg [7:0] divcnt;
    reg [7:0] shift;
    reg cur_mode;
    reg scl_low;
    reg sda_low;
    // own nack copy: a status read may clear the visible fault mid-bit
    reg nack;
    wire soft_rst;
    wire tick;
    wire sw_cycle_busy;
    wire wr_target;
    wire rd_ctrl;
    wire sda_bit;

    // external reset pins cross into this domain before use
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            global_reset_pin_sync <= 2'h0;
            lrst_sync <= 2'h0;
            sda_sync <= 2'h3;
            scl_sync <= 2'h3;
        end else begin
            global_reset_pin_sync <= {global_reset_pin_sync[0], i_global_reset_pin_n};
            lrst_sync <= {lrst_sync[0], i_link_reset_n};
            sda_sync <= {sda_sync[0], i_sda_in};
            scl_sync <= {scl_sync[0], i_scl_in};
        end
    end

    assign soft_rst = ~global_reset_pin_sync[1] | ~lrst_sync[1];
    assign sda_bit = sda_sync[1];
    assign sw_cycle_busy = (state != `SBBA_ST_IDLE);
    assign wr_target = i_reg_wr & (i_reg_addr == `SBBA_OFS_TARGET);
    assign rd_ctrl = i_reg_rd & (i_reg_addr == `SBBA_OFS_CTRL);
    assign tick = (divcnt == QCYC - 8'h01);

    // pins released outside serial mode so they stay free for gpio use
    assign o_serial_mode = eeprom_present_enable;
    assign o_scl_out = 1'b0;
    assign o_sda_out = 1'b0;
    assign o_scl_oe = scl_low & eeprom_present_enable;
    assign o_sda_oe = sda_low & eeprom_present_enable;

    // software registers
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            serial_word_location <= `SBBA_RST_BYTE;
            serial_target_and_command <= `SBBA_RST_BYTE;
            addr_mode_select <= 1'b0;
            eeprom_present_enable <= 1'b0;
            o_reg_rdata <= 8'h00;
        end else if (soft_rst) begin
            serial_word_location <= `SBBA_RST_BYTE;
            serial_target_and_command <= `SBBA_RST_BYTE;
            addr_mode_select <= 1'b0;
            eeprom_present_enable <= 1'b0;
            o_reg_rdata <= 8'h00;
        end else begin
            if (i_reg_wr && i_reg_addr == `SBBA_OFS_WORD)
                serial_word_location <= i_reg_wdata;
            if (wr_target)
                serial_target_and_command <= i_reg_wdata;
            if (i_reg_wr && i_reg_addr == `SBBA_OFS_CTRL) begin
                addr_mode_select <= i_reg_wdata[`SBBA_CTRL_MODE];
                eeprom_present_enable <= i_reg_wdata[`SBBA_CTRL_ENABLE];
            end
            if (i_reg_rd) begin
                case (i_reg_addr)
                    `SBBA_OFS_DATA: o_reg_rdata <= serial_byte_buffer;
                    `SBBA_OFS_WORD: o_reg_rdata <= serial_word_location;
                    `SBBA_OFS_TARGET:
                        o_reg_rdata <= serial_target_and_command;
                    `SBBA_OFS_CTRL: o_reg_rdata <= {addr_mode_select, 1'b0,
                        sw_cycle_busy, 1'b0, eeprom_present_enable, 1'b0,
                        cycle_fault_flag, 1'b0};
                    default: o_reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // quarter-bit divider, held at zero while idle
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            divcnt <= 8'h00;
        end else if (soft_rst || !sw_cycle_busy || tick) begin
            divcnt <= 8'h00;
        end else begin
            divcnt <= divcnt + 8'h01;
        end
    end

    // bus sequencer; also owns the data register since reads fill it
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state <= `SBBA_ST_IDLE;
            nack <= 1'b0;
            step <= 3'h0;
            quarter <= 2'h0;
            bitcnt <= 4'h0;
            shift <= 8'h00;
            cur_mode <= 1'b0;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
            cycle_fault_flag <= 1'b0;
            serial_byte_buffer <= `SBBA_RST_BYTE;
        end else if (soft_rst) begin
            state <= `SBBA_ST_IDLE;
            nack <= 1'b0;
            step <= 3'h0;
            quarter <= 2'h0;
            bitcnt <= 4'h0;
            shift <= 8'h00;
            cur_mode <= 1'b0;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
            cycle_fault_flag <= 1'b0;
            serial_byte_buffer <= `SBBA_RST_BYTE;
        end else begin
            if (rd_ctrl)
                cycle_fault_flag <= 1'b0;
            if (i_reg_wr && i_reg_addr == `SBBA_OFS_DATA)
                serial_byte_buffer <= i_reg_wdata;
            case (state)
                `SBBA_ST_IDLE: begin
                    scl_low <= 1'b0;
                    sda_low <= 1'b0;
                    quarter <= 2'h0;
                    // launch ignored unless the pins are in serial mode
                    if (wr_target && eeprom_present_enable) begin
                        state <= `SBBA_ST_START;
                        step <= 3'h0;
                        nack <= 1'b0;
                        cur_mode <= addr_mode_select;
                    end
                end
                `SBBA_ST_START, `SBBA_ST_RSTART: if (tick) begin
                    quarter <= quarter + 2'h1;
                    case (quarter)
                        2'h0: begin
                            scl_low <= 1'b0;
                            sda_low <= 1'b0;
                        end
                        2'h1: scl_low <= 1'b0;
                        2'h2: sda_low <= 1'b1;
                        default: begin
                            scl_low <= 1'b1;
                            bitcnt <= 4'h0;
                            state <= `SBBA_ST_SEND;
                            if (state == `SBBA_ST_RSTART) begin
                                step <= 3'h3;
                                shift <= {serial_target_and_command[7:1],
                                    1'b1};
                            end else begin
                                shift <= {serial_target_and_command[7:1],
                                    cur_mode &
                                    serial_target_and_command[`SBBA_TGT_RW]};
                            end
                        end
                    endcase
                end
                `SBBA_ST_SEND, `SBBA_ST_RECV: if (tick) begin
                    quarter <= quarter + 2'h1;
                    case (quarter)
                        2'h0: begin
                            scl_low <= 1'b1;
                            // ack slot released: a read answers with nack
                            if (bitcnt == 4'h8)
                                sda_low <= 1'b0;
                            else if (state == `SBBA_ST_SEND)
                                sda_low <= ~shift[7];
                            else
                                sda_low <= 1'b0;
                        end
                        2'h1: scl_low <= 1'b0;
                        2'h2: begin
                            if (bitcnt != 4'h8)
                                shift <= {shift[6:0], sda_bit};
                            else if (state == `SBBA_ST_SEND && sda_bit) begin
                                nack <= 1'b1;
                                cycle_fault_flag <= 1'b1;
                            end
                        end
                        default: begin
                            scl_low <= 1'b1;
                            bitcnt <= bitcnt + 4'h1;
                            if (bitcnt == 4'h8) begin
                                bitcnt <= 4'h0;
                                if (state == `SBBA_ST_RECV) begin
                                    serial_byte_buffer <= shift;
                                    state <= `SBBA_ST_STOP;
                                end else if (nack) begin
                                    state <= `SBBA_ST_STOP;
                                end else begin
                                    case (step)
                                        3'h0: begin
                                            if (cur_mode &&
                                      serial_target_and_command[`SBBA_TGT_RW])
                                                state <= `SBBA_ST_RECV;
                                            else if (cur_mode) begin
                                                step <= 3'h2;
                                                shift <= serial_byte_buffer;
                                            end else begin
                                                step <= 3'h1;
                                                shift <= serial_word_location;
                                            end
                                        end
                                        3'h1: begin
                                          if (serial_target_and_command[0])
                                                state <= `SBBA_ST_RSTART;
                                            else begin
                                                step <= 3'h2;
                                                shift <= serial_byte_buffer;
                                            end
                                        end
                                        3'h3: state <= `SBBA_ST_RECV;
                                        default: state <= `SBBA_ST_STOP;
                                    endcase
                                end
                            end
                        end
                    endcase
                end
                `SBBA_ST_STOP: if (tick) begin
                    quarter <= quarter + 2'h1;
                    case (quarter)
                        2'h0: sda_low <= 1'b1;
                        2'h1: scl_low <= 1'b0;
                        2'h2: sda_low <= 1'b0;
                        default: state <= `SBBA_ST_IDLE;
                    endcase
                end
                default: state <= `SBBA_ST_IDLE;
            endcase
        end
    end
endmodule // sbba_serial_bus_byte_access
`default_nettype wire

// file: rtl/unused_placeholder_none.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: verif/sbba_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sbba_chk (
    input wire i_clock,
    input wire i_rst,
    input wire i_global_reset_pin_n,
    input wire i_link_reset_n,
    input wire [7:0] i_reg_addr,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [7:0] i_reg_wdata,
    input wire [7:0] o_reg_rdata,
    input wire i_scl_in,
    input wire o_scl_out,
    input wire o_scl_oe,
    input wire i_sda_in,
    input wire o_sda_out,
    input wire o_sda_oe,
    input wire o_serial_mode
);
    // reset pins act through a synchroniser, so stay quiet a while after
    reg [2:0] pin_cnt;
    reg [9:0] hi_cnt;
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            pin_cnt <= 3'h7;
            hi_cnt <= 10'h000;
        end else begin
            pin_cnt <= !(i_global_reset_pin_n && i_link_reset_n) ? 3'h0 :
                (pin_cnt == 3'h7) ? pin_cnt : pin_cnt + 3'h1;
            hi_cnt <= o_scl_oe ? 10'h000 :
                (&hi_cnt ? hi_cnt : hi_cnt + 10'h001);
        end
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst || pin_cnt != 3'h7);
    sequence tgt_launch;
        i_reg_wr && i_reg_addr == 8'hb2 && o_serial_mode;
    endsequence
    sequence busy_poll;
        tgt_launch ##2 (i_reg_rd && i_reg_addr == 8'hb3);
    endsequence
    sequence word_wr_rd;
        (i_reg_wr && i_reg_addr == 8'hb1) ##2
            (i_reg_rd && i_reg_addr == 8'hb1);
    endsequence
    chk_open_drain: assert property (!o_scl_out && !o_sda_out)
        else $error("pin output level not low");
    chk_pins_gated: assert property (
        !o_serial_mode |-> !o_scl_oe && !o_sda_oe)
        else $error("pins driven while disabled");
    chk_mode_write: assert property (
        i_reg_wr && i_reg_addr == 8'hb3 |=>
            o_serial_mode == $past(i_reg_wdata[3]))
        else $error("pin mode not taken from write");
    chk_start_launch: assert property (
        tgt_launch |-> ##[1:400] o_sda_oe)
        else $error("target write started no cycle");
    chk_start_shape: assert property (
        $rose(o_sda_oe) && !o_scl_oe |-> ##[103:107] $rose(o_scl_oe))
        else $error("start condition timing wrong");
    chk_scl_high: assert property (
        $rose(o_scl_oe) && hi_cnt < 10'd300 |->
            hi_cnt >= 10'd208 && hi_cnt <= 10'd212)
        else $error("clock high phase length wrong");
    chk_rdata_hold: assert property (
        !i_reg_rd |=> $stable(o_reg_rdata))
        else $error("read data changed without read");
    chk_busy_set: assert property (busy_poll |=> o_reg_rdata[5])
        else $error("busy flag not set after launch");
    chk_word_back: assert property (
        word_wr_rd |=> o_reg_rdata == $past(i_reg_wdata, 3))
        else $error("word register readback wrong");
endmodule // sbba_chk
`default_nettype wire

// file: verif/sbba_eeprom_model.sv
`timescale 1ns/1ps
`default_nettype none
module sbba_eeprom_model #(parameter logic [6:0] TGT = 7'h50) (
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_pull
);
    logic [7:0] mem [0:255];
    logic [7:0] ptr, sh, tx;
    logic rd = 1'b0;
    logic sel = 1'b0;
    int bitc = 0;
    int idx = 0;
    initial o_pull = 1'b0;
    always @(negedge i_sda) if (i_scl) begin
        bitc = 0;
        idx = 0;
        rd = 1'b0;
        sel = 1'b1;
    end
    always @(posedge i_sda) if (i_scl) sel = 1'b0;
    always @(posedge i_scl) if (sel) begin
        sh = {sh[6:0], i_sda};
        bitc = bitc + 1;
        if (rd && bitc == 9 && i_sda) sel = 1'b0;
    end
    always @(negedge i_scl) if (sel) begin
        o_pull = 1'b0;
        if (bitc == 8 && !rd) begin
            if (idx == 0) begin
                sel = (sh[7:1] == TGT);
                rd = sh[0];
            end else if (idx == 1)
                ptr = sh;
            else
                mem[ptr] = sh;
            o_pull = sel;
            idx = idx + 1;
        end else if (bitc == 9) begin
            bitc = 0;
            tx = mem[ptr];
        end
        if (rd && bitc < 8) o_pull = !tx[7 - bitc];
    end
endmodule // sbba_eeprom_model
`default_nettype wire

// file: verif/test_serial_bus_byte_access.sv
`timescale 1ns/1ps
`default_nettype none
module test_serial_bus_byte_access;
    localparam logic [6:0] TGT = 7'h50;
    logic i_clock = 1'b0, i_rst = 1'b1, gpin_n = 1'b1, lpin_n = 1'b1;
    logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, seen, d, w;
    logic i_reg_wr = 1'b0, i_reg_rd = 1'b0, arm = 1'b0, want = 1'b0, pull;
    wire scl_oe, sda_oe;
    wire scl_w = !scl_oe;
    wire sda_w = !(sda_oe || pull);
    wire [7:0] o_reg_rdata;
    logic [7:0] exp_q [$];
    int err_count = 0, checked = 0, i;
    integer seed = 32'h54b4cf16;
    always #20 i_clock = ~i_clock;
    sbba_serial_bus_byte_access dut_u (
        .i_clock(i_clock), .i_rst(i_rst), .i_global_reset_pin_n(gpin_n),
        .i_link_reset_n(lpin_n), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .i_scl_in(scl_w), .o_scl_out(),
        .o_scl_oe(scl_oe), .i_sda_in(sda_w), .o_sda_out(), .o_sda_oe(sda_oe),
        .o_serial_mode());
    sbba_eeprom_model #(.TGT(TGT)) peer_u (.i_scl(scl_w), .i_sda(sda_w),
        .o_pull(pull));
    task automatic chk(input logic [7:0] v, input logic [7:0] e);
        checked++;
        if (v !== e) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, v, e);
        end
    endtask
    task automatic conclude;
        if (err_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // one register access; reads note their expectation for the monitor
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] v,
        input logic k);
        i_reg_wr = wr;
        i_reg_rd = !wr;
        i_reg_addr = a;
        i_reg_wdata = v;
        want = k;
        if (k) exp_q.push_back(v);
        @(posedge i_clock);
        #1;
        i_reg_wr = 1'b0;
        i_reg_rd = 1'b0;
        @(posedge i_clock);
        #1;
        seen = o_reg_rdata;
    endtask
    // first poll lands two cycles after launch, then every ~100 cycles
    task automatic idle_wait;
        int n = 0;
        seen = 8'h20;
        while (seen[5] && n < 400) begin
            acc(1'b0, 8'hb3, 8'h00, 1'b0);
            repeat (100) @(posedge i_clock);
            #1;
            n++;
        end
        chk(seen & 8'h20, 8'h00);
    endtask
    always @(posedge i_clock) begin
        if (arm) chk(o_reg_rdata, exp_q.pop_front());
        arm <= i_reg_rd && want;
    end
    initial begin
        repeat (16) @(posedge i_clock);
        #1;
        i_rst = 1'b0;
        d = 8'($random(seed));
        w = 8'($random(seed));
        for (i = 0; i < 5; i++) acc(1'b0, 8'hb0 + i[7:0], 8'h00, 1'b1);
        acc(1'b1, 8'hb3, 8'h08, 1'b0);
        acc(1'b0, 8'hb3, 8'h08, 1'b1);
        acc(1'b1, 8'hb0, d, 1'b0);
        acc(1'b1, 8'hb1, w, 1'b0);
        acc(1'b0, 8'hb1, w, 1'b1);
        acc(1'b1, 8'hb2, {TGT, 1'b0}, 1'b0);
        idle_wait;
        acc(1'b1, 8'hb0, ~d, 1'b0);
        acc(1'b1, 8'hb2, {TGT, 1'b1}, 1'b0);
        idle_wait;
        acc(1'b0, 8'hb0, d, 1'b1);
        // target-only mode relies on the pointer left by the last read
        acc(1'b1, 8'hb3, 8'h88, 1'b0);
        acc(1'b1, 8'hb0, ~d, 1'b0);
        acc(1'b1, 8'hb2, {TGT, 1'b1}, 1'b0);
        idle_wait;
        acc(1'b0, 8'hb0, d, 1'b1);
        acc(1'b0, 8'hb2, {TGT, 1'b1}, 1'b1);
        acc(1'b1, 8'hb2, {~TGT, 1'b0}, 1'b0);
        // no polling here: a status read would clear the fault early
        repeat (5000) @(posedge i_clock);
        #1;
        acc(1'b0, 8'hb3, 8'h8a, 1'b1);
        acc(1'b0, 8'hb3, 8'h88, 1'b1);
        for (i = 0; i < 2; i++) begin
            acc(1'b1, 8'hb1, w, 1'b0);
            if (i == 0) gpin_n = 1'b0;
            else lpin_n = 1'b0;
            repeat (4) @(posedge i_clock);
            #1;
            gpin_n = 1'b1;
            lpin_n = 1'b1;
            repeat (4) @(posedge i_clock);
            #1;
            acc(1'b0, 8'hb1, 8'h00, 1'b1);
            acc(1'b0, 8'hb3, 8'h00, 1'b1);
        end
        conclude;
    end
    initial begin
        repeat (90000) @(posedge i_clock);
        err_count++;
        conclude;
    end
endmodule // test_serial_bus_byte_access
bind sbba_serial_bus_byte_access sbba_chk chk_u (
    .i_clock(i_clock), .i_rst(i_rst),
    .i_global_reset_pin_n(i_global_reset_pin_n),
    .i_link_reset_n(i_link_reset_n), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_scl_in(i_scl_in), .o_scl_out(o_scl_out),
    .o_scl_oe(o_scl_oe), .i_sda_in(i_sda_in), .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe), .o_serial_mode(o_serial_mode));
`default_nettype wire
